//--- cld_lock_detector.sv
// Lock detector top: acquisition sequencer, pin logic and AHB-Lite registers
// Function
// RULE_01: Error over 1000 ppm raises loss_of_lock and starts acquisition.
// RULE_02: Each acquisition starts oscillator at bottom code (10 MHz), then steps up.
// RULE_03: Acquisition uses large steps first, shrinking them near the target.
// RULE_04: loss_of_lock drops once within 250 ppm of data frequency.
// RULE_05: After lock, frequency loop off; phase and delay loops take over.
// RULE_06: Modes: reference-free, reference-aided, and sticky pin indication.
// RULE_07: Locked normal mode: error above 0.1% reasserts and restarts from bottom.
// RULE_08: Setup bit 0 set to 1 selects reference-aided lock.
// RULE_09: Host also programs range bits 7:6 and divide bits 5:2.
// RULE_10: Reference mode compares against divided reference; locks within 250 ppm.
// RULE_11: Reference mode locked: error over 1000 ppm reacquires against reference.
// RULE_12: Status bit 4 sticky flag sets on any loss and stays set.
// RULE_13: Writing 1 then 0 to control bit 6 clears sticky flag.
// RULE_14: Control bit 7 at 1 makes pin mirror the sticky flag.
// RULE_15: Pin mode resets to 0; pin then shows live acquisition status.
// RULE_16: Sticky flag held clear while clear bit is 1.
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "cld_defs.svh"
module cld_lock_detector #(
	parameter int WIN = `CLD_WIN_TICKS,
	parameter logic [15:0] STEP_INIT = `CLD_STEP_INIT
)(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Frequency ticks
	input wire logic i_osc_tick,
	input wire logic i_data_tick,
	input wire logic i_ref_tick,
	// Loop controls and pins
	output logic o_lol,
	output logic [15:0] o_osc_code,
	output logic o_fll_en,
	output logic o_pll_en,
	output logic [1:0] o_ref_range,
	output logic o_irq
);
	cld_meas_if mif();
	cld_pkg::cld_state_e st_q;
	cld_pkg::cld_state_e st_d;
	cld_pkg::cld_code_t code_q;
	cld_pkg::cld_code_t step_q;
	logic [7:0] setup_q;
	logic [7:0] ctrl_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic lol_live_q;
	logic sticky;
	logic loss_evt;
	logic lock_evt;
	logic wr_q;
	logic [7:0] wa_q;
	logic take;
	logic [7:0] ra;
	logic [31:0] rd;
	logic rd_stat_clr;

	// Saturating add and subtract keep the code inside the oscillator range
	function automatic cld_pkg::cld_code_t sat_add(input cld_pkg::cld_code_t a,
		input cld_pkg::cld_code_t b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[16] ? `CLD_OSC_TOP : s[15:0];
	endfunction
	function automatic cld_pkg::cld_code_t half_step(input cld_pkg::cld_code_t s);
		half_step = (s > `CLD_STEP_MIN) ? (s >> 1) : `CLD_STEP_MIN;
	endfunction

	cld_freq_meas #(.WIN(WIN)) u_meas (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_osc_tick(i_osc_tick),
		.i_data_tick(i_data_tick),
		.i_ref_tick(i_ref_tick),
		.m(mif.meas)
	);

	cld_sticky u_sticky (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_loss_evt(loss_evt),
		.i_clr_bit(ctrl_q[`CLD_CTRL_CLR_BIT]),
		.o_sticky(sticky)
	);

	// Divided reference replaces data as the target in reference mode
	assign mif.ref_mode = setup_q[`CLD_SETUP_REF_BIT]; // see RULE_06 see RULE_10
	assign mif.div = setup_q[`CLD_SETUP_DIV_LSB +: 4]; // see RULE_09

	// Register bus decode
	assign take = i_hsel && i_hready && i_htrans[1] && (i_hsize == 3'b010);
	assign ra = i_haddr[7:0];
	assign rd_stat_clr = take && !i_hwrite && (ra == `CLD_OFF_IRQ_STAT);

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			cld_pkg::cld_st_restart: st_d = cld_pkg::cld_st_coarse;
			cld_pkg::cld_st_coarse:
				if (mif.done && mif.in_lock)
					st_d = cld_pkg::cld_st_locked; // see RULE_04 see RULE_10
				else if (mif.done && mif.near)
					st_d = cld_pkg::cld_st_fine; // see RULE_03
			cld_pkg::cld_st_fine:
				if (mif.done && mif.in_lock)
					st_d = cld_pkg::cld_st_locked; // see RULE_04 see RULE_10
			cld_pkg::cld_st_locked:
				if (mif.done && mif.out_lock)
					st_d = cld_pkg::cld_st_restart; // see RULE_01 see RULE_07 see RULE_11
			default: st_d = cld_pkg::cld_st_restart;
		endcase
		// A mode switch invalidates the current target
		if (wr_q && wa_q == `CLD_OFF_SETUP
			&& i_hwdata[`CLD_SETUP_REF_BIT] != setup_q[`CLD_SETUP_REF_BIT])
			st_d = cld_pkg::cld_st_restart; // see RULE_08
	end

	assign loss_evt = st_q == cld_pkg::cld_st_locked && st_d == cld_pkg::cld_st_restart;
	assign lock_evt = st_q != cld_pkg::cld_st_locked && st_d == cld_pkg::cld_st_locked;

	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
			st_q <= cld_pkg::cld_st_restart;
		else
			st_q <= st_d;

	// Oscillator code and step sequencing
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			code_q <= `CLD_OSC_BOTTOM;
			step_q <= STEP_INIT;
			mif.restart <= 1'b1;
		end
		else
		begin
			mif.restart <= 1'b0;
			if (st_q == cld_pkg::cld_st_restart)
			begin
				code_q <= `CLD_OSC_BOTTOM; // see RULE_02 see RULE_07
				step_q <= STEP_INIT; // see RULE_03
				mif.restart <= 1'b1;
			end
			else if (mif.done && !mif.in_lock && st_q != cld_pkg::cld_st_locked)
			begin
				mif.restart <= 1'b1;
				if (st_q == cld_pkg::cld_st_coarse && !mif.near)
					code_q <= sat_add(code_q, step_q); // see RULE_02 see RULE_03
				else
				begin
					step_q <= half_step(step_q); // see RULE_03
					if (mif.osc_slow)
						code_q <= sat_add(code_q, half_step(step_q));
					else if (code_q > half_step(step_q))
						code_q <= code_q - half_step(step_q);
					else
						code_q <= `CLD_OSC_BOTTOM;
				end
			end
		end

	// Loop enables and live lock status follow the next state
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			lol_live_q <= 1'b1;
			o_fll_en <= 1'b1;
			o_pll_en <= 1'b0;
		end
		else
		begin
			lol_live_q <= st_d != cld_pkg::cld_st_locked; // see RULE_01 see RULE_04
			o_fll_en <= st_d != cld_pkg::cld_st_locked; // see RULE_05
			o_pll_en <= st_d == cld_pkg::cld_st_locked; // see RULE_05
		end

	// Pin source selection
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
			o_lol <= 1'b1;
		else if (ctrl_q[`CLD_CTRL_PIN_BIT])
			o_lol <= sticky; // see RULE_14
		else
			o_lol <= lol_live_q; // see RULE_15

	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			o_osc_code <= `CLD_OSC_BOTTOM;
			o_ref_range <= 2'h0;
		end
		else
		begin
			o_osc_code <= code_q;
			o_ref_range <= setup_q[`CLD_SETUP_RANGE_LSB +: 2]; // see RULE_09
		end

	// Write data phase
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
		end
		else if (i_hready)
		begin
			wr_q <= take && i_hwrite;
			wa_q <= ra;
		end

	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			setup_q <= `CLD_SETUP_RST;
			ctrl_q <= `CLD_CTRL_RST; // see RULE_15
			irq_mask_q <= 2'h0;
		end
		else if (wr_q)
			case (wa_q)
				`CLD_OFF_SETUP: setup_q <= i_hwdata[7:0]; // see RULE_08
				`CLD_OFF_CTRL: ctrl_q <= i_hwdata[7:0]; // see RULE_13 see RULE_14
				`CLD_OFF_IRQ_MASK: irq_mask_q <= i_hwdata[1:0];
				default: ;
			endcase

	// Read clears status; a same-cycle event still lands
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
			irq_stat_q <= 2'h0;
		else
			irq_stat_q <= (irq_stat_q & {2{!rd_stat_clr}}) | {lock_evt, loss_evt};

	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_stat_q & irq_mask_q);

	always_comb
	begin
		rd = 32'h0;
		case (ra)
			`CLD_OFF_SETUP: rd = {24'h0, setup_q};
			`CLD_OFF_CTRL: rd = {24'h0, ctrl_q};
			`CLD_OFF_STATUS: rd = {24'h0, 3'h0, sticky, 1'b0, st_q, lol_live_q}; // see RULE_12
			`CLD_OFF_IRQ_STAT: rd = {30'h0, irq_stat_q};
			`CLD_OFF_IRQ_MASK: rd = {30'h0, irq_mask_q};
			`CLD_OFF_OSC_CODE: rd = {16'h0, code_q};
			default: rd = 32'h0;
		endcase
	end

	// Zero wait states; read data captured at the address phase
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			o_hrdata <= 32'h0;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
		else
		begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			if (take && !i_hwrite)
				o_hrdata <= rd;
		end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	property p_unlock;
		st_q == cld_pkg::cld_st_locked && mif.done && mif.out_lock |=> lol_live_q ##1 st_q == cld_pkg::cld_st_coarse;
	endproperty
	a_unlock: assert property (p_unlock) else $error("lock loss not flagged"); // see RULE_01
	property p_bottom;
		st_q == cld_pkg::cld_st_restart |=> code_q == `CLD_OSC_BOTTOM && step_q == STEP_INIT;
	endproperty
	a_bottom: assert property (p_bottom) else $error("acquisition not from bottom"); // see RULE_02
	property p_shrink;
		st_q == cld_pkg::cld_st_fine && mif.done |=> step_q <= $past(step_q);
	endproperty
	a_shrink: assert property (p_shrink) else $error("step grew in fine"); // see RULE_03
	property p_lock_in;
		st_q != cld_pkg::cld_st_locked && st_q != cld_pkg::cld_st_restart && mif.done
			&& mif.in_lock && !wr_q |=> !lol_live_q ##1 ($past(ctrl_q[7]) || !o_lol);
	endproperty
	a_lock_in: assert property (p_lock_in) else $error("lol not dropped"); // see RULE_04
	property p_fll_off;
		st_q == cld_pkg::cld_st_locked |-> !o_fll_en && o_pll_en;
	endproperty
	a_fll_off: assert property (p_fll_off) else $error("fll on while locked"); // see RULE_05
	property p_mode_restart;
		wr_q && wa_q == `CLD_OFF_SETUP && i_hwdata[0] != setup_q[0]
			|=> st_q == cld_pkg::cld_st_restart;
	endproperty
	a_mode_restart: assert property (p_mode_restart) else $error("mode change ignored"); // see RULE_08
	property p_pin_sticky;
		ctrl_q[7] |=> o_lol == $past(sticky);
	endproperty
	a_pin_sticky: assert property (p_pin_sticky) else $error("pin not sticky"); // see RULE_14
	property p_pin_live;
		!ctrl_q[7] |=> o_lol == $past(lol_live_q);
	endproperty
	a_pin_live: assert property (p_pin_live) else $error("pin not live"); // see RULE_15
	property p_loss_sticky;
		loss_evt && !ctrl_q[6] |=> sticky;
	endproperty
	a_loss_sticky: assert property (p_loss_sticky) else $error("loss not sticky"); // see RULE_12
	property p_code_hold;
		st_q == cld_pkg::cld_st_locked |=> $stable(code_q);
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("code moved in lock"); // see RULE_05
	property p_live_low;
		st_q == cld_pkg::cld_st_locked |-> !lol_live_q;
	endproperty
	a_live_low: assert property (p_live_low) else $error("lol high in lock"); // see RULE_04
	property p_coarse_up;
		st_q == cld_pkg::cld_st_coarse && mif.done && !mif.near && !mif.in_lock
			|=> code_q > $past(code_q) || code_q == `CLD_OSC_TOP;
	endproperty
	a_coarse_up: assert property (p_coarse_up) else $error("coarse step not up"); // see RULE_02
	property p_to_fine;
		st_q == cld_pkg::cld_st_coarse && mif.done && mif.near && !mif.in_lock && !wr_q
			|=> st_q == cld_pkg::cld_st_fine;
	endproperty
	a_to_fine: assert property (p_to_fine) else $error("fine phase skipped"); // see RULE_03
	c_lock: cover property (st_q == cld_pkg::cld_st_fine ##1 st_q == cld_pkg::cld_st_locked);
	c_relock: cover property (loss_evt ##1 st_q == cld_pkg::cld_st_restart);
	c_ref: cover property (setup_q[0] && lock_evt);
endmodule

//--- cld_defs.svh
// Offsets, field positions, reset values and counts for the lock detector
`ifndef CLD_DEFS_SVH
`define CLD_DEFS_SVH
`define CLD_OFF_SETUP 8'h00
`define CLD_OFF_CTRL 8'h04
`define CLD_OFF_STATUS 8'h08
`define CLD_OFF_IRQ_STAT 8'h0C
`define CLD_OFF_IRQ_MASK 8'h10
`define CLD_OFF_OSC_CODE 8'h14
`define CLD_SETUP_REF_BIT 0
`define CLD_SETUP_DIV_LSB 2
`define CLD_SETUP_RANGE_LSB 6
`define CLD_CTRL_CLR_BIT 6
`define CLD_CTRL_PIN_BIT 7
`define CLD_STAT_LIVE_BIT 0
`define CLD_STAT_STICKY_BIT 4
`define CLD_SETUP_RST 8'h00
`define CLD_CTRL_RST 8'h00
`define CLD_IRQ_LOSS 0
`define CLD_IRQ_LOCK 1
`define CLD_WIN_TICKS 16384
`define CLD_PPM_SCALE 1000000
`define CLD_LOCK_PPM 250
`define CLD_UNLOCK_PPM 1000
`define CLD_NEAR_DIV 100
`define CLD_OSC_BOTTOM 16'h0000
`define CLD_OSC_TOP 16'hFFFF
`define CLD_STEP_INIT 16'h1000
`define CLD_STEP_MIN 16'h0001
`endif

//--- cld_pkg.sv
// Types shared by the lock detector modules
package cld_pkg;
	typedef enum logic [1:0]
	{
		cld_st_restart = 2'b00,
		cld_st_coarse = 2'b01,
		cld_st_fine = 2'b11,
		cld_st_locked = 2'b10
	} cld_state_e;
	typedef logic [15:0] cld_code_t;
endpackage

//--- cld_meas_if.sv
// Measurement request and result bundle
`timescale 1ns/100ps
interface cld_meas_if;
	logic restart;
	logic ref_mode;
	logic [3:0] div;
	logic done;
	logic osc_slow;
	logic in_lock;
	logic out_lock;
	logic near;
	modport meas (input restart, ref_mode, div, output done, osc_slow, in_lock, out_lock, near);
	modport ctl (output restart, ref_mode, div, input done, osc_slow, in_lock, out_lock, near);
endinterface

//--- cld_freq_meas.sv
// Windowed frequency comparison of oscillator against data or reference
`timescale 1ns/100ps
`include "cld_defs.svh"
module cld_freq_meas #(
	parameter int WIN = `CLD_WIN_TICKS
)(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Tick pulses
	input wire logic i_osc_tick,
	input wire logic i_data_tick,
	input wire logic i_ref_tick,
	// Results
	cld_meas_if.meas m
);
	logic [31:0] tgt_q;
	logic [31:0] osc_q;
	logic [31:0] inc;
	logic [39:0] adiff;
	logic fin;
	logic armed_q;

	// Error of d against t within ppm, widened so the product cannot wrap
	function automatic logic ppm_ok(input logic [39:0] d, input logic [31:0] t,
		input logic [31:0] ppm);
		ppm_ok = (64'(d) * 64'(`CLD_PPM_SCALE)) <= (64'(t) * 64'(ppm));
	endfunction

	// Reference ticks are weighted by the divide ratio
	assign inc = m.ref_mode ? (m.div + 32'h1) & {32{i_ref_tick}} : {31'h0, i_data_tick};
	assign fin = tgt_q >= 32'(WIN);
	assign adiff = (osc_q >= tgt_q) ? 40'(osc_q - tgt_q) : 40'(tgt_q - osc_q);

	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			tgt_q <= 32'h0;
			osc_q <= 32'h0;
		end
		else if (m.restart || fin)
		begin
			tgt_q <= 32'h0;
			osc_q <= 32'h0;
		end
		else if (armed_q)
		begin
			tgt_q <= tgt_q + inc;
			osc_q <= osc_q + {31'h0, i_osc_tick};
		end

	// Reference windows open on a reference tick; a free start blurs the count by a whole period
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
			armed_q <= 1'b0;
		else if (m.restart || fin)
			armed_q <= !m.ref_mode;
		else if (i_ref_tick)
			armed_q <= 1'b1;

	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			m.done <= 1'b0;
			m.osc_slow <= 1'b0;
			m.in_lock <= 1'b0;
			m.out_lock <= 1'b0;
			m.near <= 1'b0;
		end
		else
		begin
			m.done <= fin && !m.restart;
			m.osc_slow <= osc_q < tgt_q;
			m.in_lock <= ppm_ok(adiff, tgt_q, `CLD_LOCK_PPM);
			m.out_lock <= !ppm_ok(adiff, tgt_q, `CLD_UNLOCK_PPM);
			m.near <= (64'(adiff) * 64'(`CLD_NEAR_DIV)) <= 64'(tgt_q);
		end
endmodule

//--- cld_sticky.sv
// Sticky loss-of-lock flag with held clear
`timescale 1ns/100ps
module cld_sticky (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Events and clear level
	input wire logic i_loss_evt,
	input wire logic i_clr_bit,
	// Flag
	output logic o_sticky
);
	// Clear level wins while held, so the 1-then-0 sequence ends clean
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn)
			o_sticky <= 1'b0;
		else if (i_clr_bit)
			o_sticky <= 1'b0; // see RULE_13 see RULE_16
		else if (i_loss_evt)
			o_sticky <= 1'b1; // see RULE_12

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	property p_sticky_set;
		i_loss_evt && !i_clr_bit |=> o_sticky [*2] or (o_sticky ##1 $past(i_clr_bit,1) || i_clr_bit);
	endproperty
	a_sticky_set: assert property (p_sticky_set) else $error("sticky not set"); // see RULE_12
	property p_sticky_clr;
		i_clr_bit |=> !o_sticky;
	endproperty
	a_sticky_clr: assert property (p_sticky_clr) else $error("sticky not held clear"); // see RULE_16
	property p_sticky_stay;
		!i_clr_bit && o_sticky |=> o_sticky;
	endproperty
	a_sticky_stay: assert property (p_sticky_stay) else $error("sticky dropped"); // see RULE_12
	c_sticky_cycle: cover property (o_sticky ##1 i_clr_bit ##1 !o_sticky);
endmodule

//--- cld_tick_src.sv
// Tick source model: tuned oscillator, serial data stream and reference clock
`timescale 1ns/100ps
module cld_tick_src (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Rates and tuning
	input wire logic [15:0] i_code,
	input wire logic [31:0] i_data_inc,
	input wire logic [31:0] i_ref_inc,
	// Ticks
	output logic o_osc_tick,
	output logic o_data_tick,
	output logic o_ref_tick
);
	logic [31:0] osc_q;
	logic [31:0] data_q;
	logic [31:0] ref_q;
	logic [31:0] osc_inc;
	// Rate rises with the code from the bottom; near one tick per clock keeps windows short
	assign osc_inc = 32'hE0000000 + {3'h0, i_code, 13'h0};
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			{o_osc_tick, osc_q} <= 33'h0;
			{o_data_tick, data_q} <= 33'h0;
			{o_ref_tick, ref_q} <= 33'h0;
		end
		else
		begin
			{o_osc_tick, osc_q} <= {1'b0, osc_q} + {1'b0, osc_inc};
			{o_data_tick, data_q} <= {1'b0, data_q} + {1'b0, i_data_inc};
			{o_ref_tick, ref_q} <= {1'b0, ref_q} + {1'b0, i_ref_inc};
		end
	end
endmodule

//--- testbench.sv
// Self-checking bench for the lock detector
`timescale 1ns/100ps
`include "cld_defs.svh"
module testbench;
	localparam int WIN_T = 1024;
	localparam logic [15:0] STEP_T = 16'h2000;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hrdy;
	logic hresp;
	logic osc_t;
	logic data_t;
	logic ref_t;
	logic loss_of_lock;
	logic fll;
	logic pll;
	logic irq;
	logic [15:0] code;
	logic [1:0] rrange;
	logic [31:0] data_inc = 32'hF0000000;
	logic [31:0] ref_inc = 32'h80000000;
	logic [31:0] inc;
	logic [31:0] rd;
	logic [15:0] prev_code = 16'h0;
	logic [15:0] last_step = 16'h0;
	logic [15:0] d;
	logic first_step = 1'b1;
	logic [15:0] tgt;
	logic [3:0] div;
	logic [1:0] rng;
	int fails = 0;
	int compares = 0;
	int seed = 32'h613B9BEC;
	cld_lock_detector #(.WIN(WIN_T), .STEP_INIT(STEP_T)) u_cld_lock_detector (.i_clk(clk),
		.i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
		.o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_osc_tick(osc_t),
		.i_data_tick(data_t), .i_ref_tick(ref_t), .o_lol(loss_of_lock), .o_osc_code(code),
		.o_fll_en(fll), .o_pll_en(pll), .o_ref_range(rrange), .o_irq(irq));
	cld_tick_src u_cld_tick_src (.i_clk(clk), .i_resetn(resetn), .i_code(code),
		.i_data_inc(data_inc), .i_ref_inc(ref_inc), .o_osc_tick(osc_t),
		.o_data_tick(data_t), .o_ref_tick(ref_t));
	initial
	begin
		forever
			#2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hrdy !== 1'b1)
			@(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hrdy !== 1'b1)
			@(posedge clk);
		rd = hrdata;
	endtask
	// Bounded wait on the pin (0) or the frequency loop enable (1)
	task automatic wait_sig(input int which, input logic v);
		for (int n = 0; n < 60000 && (which == 0 ? loss_of_lock : fll) !== v; n++)
			@(posedge clk);
	endtask
	function automatic logic [15:0] code_of(input logic [31:0] i);
		logic [31:0] t;
		t = i - 32'hE0000000;
		return t[28:13];
	endfunction
	// Loose tolerance: a short window resolves only about one tick
	function automatic logic near(input logic [15:0] c, input logic [15:0] e);
		return ((c > e) ? c - e : e - c) <= 16'h0400;
	endfunction
	function automatic logic [31:0] inc_of(input logic [15:0] c);
		return 32'hE0000000 + {3'h0, c, 13'h0};
	endfunction
	// Target kept off the coarse grid, so a coarse step never lands in lock
	function automatic logic [15:0] pick_tgt(input logic [31:0] r);
		return {2'b01, r[13], 13'h0800 + {1'b0, r[11:0]}};
	endfunction
	// Step sizes taken by the acquisition
	always @(posedge clk)
	begin
		if (fll === 1'b1 && code !== prev_code)
		begin
			if (code === 16'h0000)
				first_step = 1'b1;
			else
			begin
				d = (code > prev_code) ? code - prev_code : prev_code - code;
				if (first_step)
					chk(d, STEP_T);
				first_step = 1'b0;
				last_step = d;
			end
		end
		prev_code = code;
	end
	initial
	begin
		repeat (95000) @(posedge clk);
		fails++;
		end_sim();
	end
	initial
	begin
		tgt = pick_tgt($random(seed));
		data_inc <= inc_of(tgt);
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk(loss_of_lock, 1'b1);
		ahb(1'b0, `CLD_OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, `CLD_OFF_SETUP, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		ahb(1'b1, `CLD_OFF_IRQ_MASK, 32'h1);
		wait_sig(0, 1'b0);
		chk({loss_of_lock, fll, pll}, 3'b001);
		chk(near(code, tgt), 1'b1);
		chk(last_step < STEP_T, 1'b1);
		chk(irq, 1'b0);
		ahb(1'b0, `CLD_OFF_STATUS, 32'h0);
		chk(rd & 32'h11, 32'h0);
		ahb(1'b1, `CLD_OFF_CTRL, 32'h80);
		repeat (4) @(posedge clk);
		chk(loss_of_lock, 1'b0);
		inc = data_inc + (data_inc >> 6);
		tgt = code_of(inc);
		data_inc <= inc;
		wait_sig(1, 1'b1);
		repeat (2) @(posedge clk);
		chk(code, 16'h0000);
		repeat (4) @(posedge clk);
		chk({loss_of_lock, irq}, 2'b11);
		ahb(1'b0, `CLD_OFF_IRQ_STAT, 32'h0);
		chk(rd[0], 1'b1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wait_sig(1, 1'b0);
		repeat (4) @(posedge clk);
		chk(loss_of_lock, 1'b1);
		chk(near(code, tgt), 1'b1);
		ahb(1'b0, `CLD_OFF_STATUS, 32'h0);
		chk(rd & 32'h11, 32'h10);
		ahb(1'b1, `CLD_OFF_CTRL, 32'hC0);
		repeat (4) @(posedge clk);
		chk(loss_of_lock, 1'b0);
		ahb(1'b0, `CLD_OFF_STATUS, 32'h0);
		chk(rd[4], 1'b0);
		ahb(1'b1, `CLD_OFF_CTRL, 32'h00);
		repeat (4) @(posedge clk);
		ahb(1'b0, `CLD_OFF_STATUS, 32'h0);
		chk({rd[4], loss_of_lock}, 2'b00);
		div = 4'($random(seed));
		rng = 2'($random(seed));
		tgt = pick_tgt($random(seed));
		inc = inc_of(tgt);
		data_inc <= inc;
		ref_inc <= inc / (32'(div) + 32'h1);
		ahb(1'b1, `CLD_OFF_SETUP, {24'h0, rng, div, 2'b01});
		repeat (4) @(posedge clk);
		chk({rrange, loss_of_lock}, {rng, 1'b1});
		wait_sig(0, 1'b0);
		chk({near(code, tgt), pll}, 2'b11);
		ahb(1'b1, `CLD_OFF_CTRL, 32'h40);
		ahb(1'b1, `CLD_OFF_CTRL, 32'h00);
		ahb(1'b0, `CLD_OFF_STATUS, 32'h0);
		chk(rd[4], 1'b0);
		ref_inc <= ref_inc + (ref_inc >> 6);
		wait_sig(0, 1'b1);
		chk({loss_of_lock, fll}, 2'b11);
		ahb(1'b0, `CLD_OFF_STATUS, 32'h0);
		chk(rd[4], 1'b1);
		end_sim();
	end
endmodule
